// ### hdl/napt_consts.vh
// Shared constants of the address and port translation engine.
// Assumes inclusion by bare name from the design file.
`ifndef NAPT_CONSTS_VH
`define NAPT_CONSTS_VH
// Timing
`define CLK_HZ          25000000
`define IDLE_TIMEOUT_S  300
`define TIMER_W         9
// Downstream internal router prefix
`define IR_FIRST_OCTET  8'h0a
`define V6_V4_LEN_DIFF  8'h28
// Protocol numbers and public port pool
`define PROTO_IGMP      8'h02
`define PORT_BASE       16'hc000
// Private address ranges
`define PRIV_A_NET      8'h0a
`define PRIV_B_NET      12'hac1
`define PRIV_C_NET      16'hc0a8
// Reset values
`define RST_ADDR        32'h00000000
`define RST_PORT        16'h0000
`endif

// ### hdl/napt_translation_engine.v
// Address and port translation engine, one packet descriptor at a time.
// Assumes header fields are parsed upstream and that all inputs come
// from logic on CLK_SYS.
//
// Summary of operation
// - Internal router IPv4 prefix starts with octet ten.
// - Octets two and three are the 16-bit link identifier bytes.
// - IPv4 prefix length is the delegated IPv6 length minus forty.
// - Route next hop is the router's DHCPv4 address.
// - Outbound private-to-public packets create entries on demand.
// - A private pair maps to the same public pair while its entry lives.
// - Inbound packets never create entries.
// - Customer-to-customer headers pass untranslated; only an announced FTP pair is mapped.
// - Outbound: record mapping, replace source with public pair.
// - Replies: look up public destination, restore the private pair.
// - Idle entries expire after 300 seconds by default.
// - Flow end may close an entry early; idle timeout still applies.
// - ICMP errors get outer and inner headers rewritten.
// - FTP announced data ports are translated through the table.
// - Private destinations are never advertised as routes.
// - Customer side uses private addresses only; others are dropped, except IGMP.
// - Many private pairs share one public address, distinct ports.
// - Customer IGMP is consumed locally, never translated.
// - Inbound packets are reverse-translated before any routing.
`include "napt_consts.vh"

module napt_translation_engine #(
  parameter             ENTRIES     = 8,
  parameter             IDX_W       = 3,
  parameter             TICK_CYCLES = `CLK_HZ,
  parameter [8:0]       IDLE_S      = `IDLE_TIMEOUT_S,
  parameter [15:0]      PORT_BASE   = `PORT_BASE
) (
  input  wire        CLK_SYS,        // System clock
  input  wire        ARST_N,         // Async reset, active low
  input  wire [31:0] PUB_ADDR,       // Public address, operator side
  input  wire        IN_VALID,       // Descriptor offered
  output reg         IN_READY,       // Engine idle, takes descriptor
  input  wire        IN_FROM_OP,     // 1: came from operator side
  input  wire [7:0]  IN_PROTO,       // IP protocol number
  input  wire        IN_ICMP_ERR,    // Packet is an ICMP error
  input  wire        IN_FLOW_END,    // TCP FIN or RST seen
  input  wire [31:0] IN_SRC_ADDR,    // Outer source address
  input  wire [15:0] IN_SRC_PORT,    // Outer source port
  input  wire [31:0] IN_DST_ADDR,    // Outer destination address
  input  wire [15:0] IN_DST_PORT,    // Outer destination port
  input  wire [31:0] IN_INR_ADDR,    // Inner endpoint on our side
  input  wire [15:0] IN_INR_PORT,    // Inner endpoint port
  input  wire        IN_FTP_VALID,   // FTP data pair announced
  input  wire [31:0] IN_FTP_ADDR,    // Announced address
  input  wire [15:0] IN_FTP_PORT,    // Announced port
  output reg         OUT_VALID,      // Result pulse
  output reg         OUT_DROP,       // Packet discarded
  output reg         OUT_LOCAL,      // Packet consumed locally
  output reg  [31:0] OUT_SRC_ADDR,   // Rewritten source address
  output reg  [15:0] OUT_SRC_PORT,   // Rewritten source port
  output reg  [31:0] OUT_DST_ADDR,   // Rewritten destination address
  output reg  [15:0] OUT_DST_PORT,   // Rewritten destination port
  output reg  [31:0] OUT_INR_ADDR,   // Rewritten inner address
  output reg  [15:0] OUT_INR_PORT,   // Rewritten inner port
  output reg  [31:0] OUT_FTP_ADDR,   // Rewritten announced address
  output reg  [15:0] OUT_FTP_PORT,   // Rewritten announced port
  input  wire        PD_VALID,       // Prefix delegated to a router
  input  wire [15:0] PD_LINK_IDENTIFIER,     // link_identifier of the prefix
  input  wire [7:0]  PD_LEN,         // Delegated IPv6 prefix length
  input  wire [31:0] PD_NEXT_HOP,    // Router DHCPv4 address
  output reg         ROUTE_VALID,    // Route install pulse
  output reg  [31:0] ROUTE_PREFIX,   // Derived IPv4 prefix
  output reg  [7:0]  ROUTE_LEN,      // Derived prefix length
  output reg  [31:0] ROUTE_NEXT_HOP, // Route next hop
  input  wire        ADV_VALID,      // Route offered for advertising
  input  wire [31:0] ADV_PREFIX,     // Offered prefix
  output reg         ADV_PASS,       // Advertisement allowed pulse
  output reg  [31:0] ADV_OUT_PREFIX  // Prefix allowed out
);

  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_FTP  = 2'h1;
  localparam [1:0] S_PKT  = 2'h2;

  // Private realm test, used for several decisions
  function is_priv(input [31:0] a);
    is_priv = (a[31:24] == `PRIV_A_NET) || (a[31:20] == `PRIV_B_NET) ||
              (a[31:16] == `PRIV_C_NET);
  endfunction

  // Public port owned by table slot k; fixed per slot
  function [15:0] pub_port(input [IDX_W-1:0] k);
    pub_port = PORT_BASE + {{(16-IDX_W){1'b0}}, k};
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Table storage and held descriptor
  reg [ENTRIES-1:0] ent_v;
  reg [31:0]        ent_addr [0:ENTRIES-1];
  reg [15:0]        ent_port [0:ENTRIES-1];
  reg [8:0]         ent_tmr  [0:ENTRIES-1];
  reg [1:0]         state;
  reg [31:0]        tick_cnt;
  reg               tick;
  reg               h_op, h_err, h_end, h_ftp, f_fail;
  reg [7:0]         h_proto;
  reg [31:0]        h_saddr, h_daddr, h_iaddr, h_faddr;
  reg [15:0]        h_sport, h_dport, h_iport, h_fport;

  //////////////////////////////////////////////////////////////////////
  // Lookup key for the current phase
  reg        key_in;
  reg [31:0] key_addr;
  reg [15:0] key_port;
  always @* begin
    key_in   = (state == S_PKT) && h_op;
    key_addr = h_saddr;
    key_port = h_sport;
    if (state == S_FTP) begin
      key_addr = h_faddr;
      key_port = h_fport;
    end else if (h_err) begin
      key_addr = h_iaddr;
      key_port = h_iport;
    end else if (h_op) begin
      key_port = h_dport;
    end
  end

  // Search for a hit and the lowest free slot
  integer i;
  reg             hit, free;
  reg [IDX_W-1:0] hit_idx, free_idx;
  always @* begin
    hit = 1'b0;
    free = 1'b0;
    hit_idx = {IDX_W{1'b0}};
    free_idx = {IDX_W{1'b0}};
    for (i = ENTRIES - 1; i >= 0; i = i - 1) begin
      if (ent_v[i] && (key_in ? key_port == pub_port(i[IDX_W-1:0]) :
          (ent_addr[i] == key_addr && ent_port[i] == key_port))) begin
        hit = 1'b1;
        hit_idx = i[IDX_W-1:0];
      end
      if (!ent_v[i]) begin
        free = 1'b1;
        free_idx = i[IDX_W-1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Packet decision
  reg             d_local, d_pass, d_drop, do_hit, do_alloc;
  reg [IDX_W-1:0] tr_idx;
  always @* begin
    d_local  = !h_op && (h_proto == `PROTO_IGMP);
    // A public source never passes, even towards a private host
    d_pass   = !h_op && is_priv(h_saddr) && is_priv(h_daddr);
    d_drop   = 1'b0;
    do_hit   = 1'b0;
    do_alloc = 1'b0;
    tr_idx   = hit ? hit_idx : free_idx;
    if (state == S_FTP) begin
      do_hit   = hit;
      do_alloc = !hit && free && is_priv(h_faddr);
    end else if (state == S_PKT && !d_local && !d_pass) begin
      if (h_op) begin
        // Only our address with a live entry gets in
        do_hit = hit && (h_daddr == PUB_ADDR);
        d_drop = !do_hit;
      end else if (!is_priv(h_saddr) || f_fail) begin
        d_drop = 1'b1;
      end else begin
        do_hit   = hit;
        // Errors never open entries; full table drops
        do_alloc = !hit && free && !h_err;
        d_drop   = !hit && (!free || h_err);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // One-second tick for idle timers
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      tick_cnt <= 32'h0;
      tick <= 1'b0;
    end else begin
      tick <= (tick_cnt == TICK_CYCLES - 1);
      tick_cnt <= (tick_cnt == TICK_CYCLES - 1) ? 32'h0 : tick_cnt + 32'h1;
    end
  end

  // Entry ageing, refresh, closing and allocation; later writes win
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      ent_v <= {ENTRIES{1'b0}};
      for (i = 0; i < ENTRIES; i = i + 1) begin
        ent_addr[i] <= `RST_ADDR;
        ent_port[i] <= `RST_PORT;
        ent_tmr[i] <= 9'h0;
      end
    end else begin
      for (i = 0; i < ENTRIES; i = i + 1) begin
        if (ent_v[i] && ent_tmr[i] == 9'h0)
          ent_v[i] <= 1'b0;
        else if (ent_v[i] && tick)
          ent_tmr[i] <= ent_tmr[i] - 9'h1;
        if (do_hit && hit_idx == i[IDX_W-1:0]) begin
          ent_tmr[i] <= IDLE_S;
          ent_v[i] <= !(state == S_PKT && h_end);
        end
        if (do_alloc && free_idx == i[IDX_W-1:0]) begin
          ent_v[i] <= 1'b1;
          ent_addr[i] <= key_addr;
          ent_port[i] <= key_port;
          ent_tmr[i] <= IDLE_S;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Sequencer and rewrite; FTP pair is mapped one cycle before the packet
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= S_IDLE;
      IN_READY <= 1'b1;
      {h_op, h_err, h_end, h_ftp, f_fail} <= 5'h0;
      h_proto <= 8'h0;
      {h_saddr, h_daddr, h_iaddr, h_faddr} <= 128'h0;
      {h_sport, h_dport, h_iport, h_fport} <= 64'h0;
      {OUT_VALID, OUT_DROP, OUT_LOCAL} <= 3'h0;
      {OUT_SRC_ADDR, OUT_DST_ADDR, OUT_INR_ADDR, OUT_FTP_ADDR} <= 128'h0;
      {OUT_SRC_PORT, OUT_DST_PORT, OUT_INR_PORT, OUT_FTP_PORT} <= 64'h0;
    end else begin
      OUT_VALID <= 1'b0;
      case (state)
        S_IDLE: begin
          if (IN_VALID) begin
            IN_READY <= 1'b0;
            h_op <= IN_FROM_OP;
            h_err <= IN_ICMP_ERR;
            h_end <= IN_FLOW_END;
            h_ftp <= IN_FTP_VALID && !IN_FROM_OP;
            f_fail <= 1'b0;
            h_proto <= IN_PROTO;
            h_saddr <= IN_SRC_ADDR;
            h_sport <= IN_SRC_PORT;
            h_daddr <= IN_DST_ADDR;
            h_dport <= IN_DST_PORT;
            h_iaddr <= IN_INR_ADDR;
            h_iport <= IN_INR_PORT;
            h_faddr <= IN_FTP_ADDR;
            h_fport <= IN_FTP_PORT;
            state <= (IN_FTP_VALID && !IN_FROM_OP) ? S_FTP : S_PKT;
          end
        end
        S_FTP: begin
          // Announced pair shares the table with ordinary flows
          f_fail <= !(do_hit || do_alloc);
          h_faddr <= PUB_ADDR;
          h_fport <= pub_port(tr_idx);
          state <= S_PKT;
        end
        S_PKT: begin
          OUT_VALID <= 1'b1;
          OUT_DROP <= d_drop;
          OUT_LOCAL <= d_local;
          OUT_SRC_ADDR <= h_saddr;
          OUT_SRC_PORT <= h_sport;
          OUT_DST_ADDR <= h_daddr;
          OUT_DST_PORT <= h_dport;
          OUT_INR_ADDR <= h_iaddr;
          OUT_INR_PORT <= h_iport;
          OUT_FTP_ADDR <= h_faddr;
          OUT_FTP_PORT <= h_fport;
          if ((do_hit || do_alloc) && !h_op) begin
            OUT_SRC_ADDR <= PUB_ADDR;
            if (h_err) begin
              OUT_INR_ADDR <= PUB_ADDR;
              OUT_INR_PORT <= pub_port(tr_idx);
            end else begin
              OUT_SRC_PORT <= pub_port(tr_idx);
            end
          end else if (do_hit) begin
            OUT_DST_ADDR <= ent_addr[hit_idx];
            if (h_err) begin
              OUT_INR_ADDR <= ent_addr[hit_idx];
              OUT_INR_PORT <= ent_port[hit_idx];
            end else begin
              OUT_DST_PORT <= ent_port[hit_idx];
            end
          end
          IN_READY <= 1'b1;
          state <= S_IDLE;
        end
        default: begin
          IN_READY <= 1'b1;
          state <= S_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Internal router route and advertisement filter
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      ROUTE_VALID <= 1'b0;
      ROUTE_PREFIX <= `RST_ADDR;
      ROUTE_LEN <= 8'h0;
      ROUTE_NEXT_HOP <= `RST_ADDR;
      ADV_PASS <= 1'b0;
      ADV_OUT_PREFIX <= `RST_ADDR;
    end else begin
      ROUTE_VALID <= PD_VALID;
      if (PD_VALID) begin
        ROUTE_PREFIX <= {`IR_FIRST_OCTET, PD_LINK_IDENTIFIER, 8'h00};
        // Short IPv6 lengths clamp to zero rather than wrap
        ROUTE_LEN <= (PD_LEN >= `V6_V4_LEN_DIFF) ?
                     PD_LEN - `V6_V4_LEN_DIFF : 8'h0;
        ROUTE_NEXT_HOP <= PD_NEXT_HOP;
      end
      ADV_PASS <= ADV_VALID && !is_priv(ADV_PREFIX);
      if (ADV_VALID)
        ADV_OUT_PREFIX <= ADV_PREFIX;
    end
  end

endmodule // napt_translation_engine

// ### tb/napt_translation_engine_properties.sv
// Checker for the translation engine: routes, filter, drop paths.
// Sees only top-level ports; bound in from the bench top.
module napt_props (
  input logic        CLK_SYS, ARST_N, IN_VALID, IN_READY, IN_FROM_OP,
  input logic        IN_FTP_VALID, OUT_VALID, OUT_DROP, OUT_LOCAL,
  input logic        PD_VALID, ROUTE_VALID, ADV_VALID, ADV_PASS,
  input logic [7:0]  IN_PROTO, PD_LEN, ROUTE_LEN,
  input logic [15:0] PD_LINK_IDENTIFIER,
  input logic [31:0] PUB_ADDR, IN_SRC_ADDR, IN_DST_ADDR, OUT_DST_ADDR,
  input logic [31:0] PD_NEXT_HOP, ROUTE_PREFIX, ROUTE_NEXT_HOP, ADV_PREFIX
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  // Private ranges, kept apart from the design's own test
  function automatic logic priv(input logic [31:0] a);
    return a[31:24] == 8'h0a || a[31:20] == 12'hac1 || a[31:16] == 16'hc0a8;
  endfunction
  // Customer descriptor taken, two-cycle answer
  wire cust = IN_VALID && IN_READY && !IN_FROM_OP && !IN_FTP_VALID;
  //////////////////////////////////////////////////////////////////////////
  property p_oct; PD_VALID |=> ROUTE_VALID && ROUTE_PREFIX[31:24] == 8'h0a;
  endproperty
  a_oct: assert property (p_oct) else $error("first octet");
  property p_link; PD_VALID |=> ROUTE_PREFIX[23:8] == $past(PD_LINK_IDENTIFIER);
  endproperty
  a_link: assert property (p_link) else $error("link octets");
  property p_len;
    PD_VALID && PD_LEN >= 8'h28 |=> ROUTE_LEN == $past(PD_LEN) - 8'h28;
  endproperty
  a_len: assert property (p_len) else $error("prefix length");
  property p_hop; PD_VALID |=> ROUTE_NEXT_HOP == $past(PD_NEXT_HOP);
  endproperty
  a_hop: assert property (p_hop) else $error("next hop");
  property p_adv; ADV_VALID && priv(ADV_PREFIX) |=> !ADV_PASS; endproperty
  a_adv: assert property (p_adv) else $error("private advert");
  property p_igmp; cust && IN_PROTO == 8'h02 |=> !OUT_VALID ##1 OUT_LOCAL;
  endproperty
  a_igmp: assert property (p_igmp) else $error("igmp not local");
  property p_srcp;
    cust && IN_PROTO != 8'h02 && !priv(IN_SRC_ADDR) |=> ##1 OUT_DROP;
  endproperty
  a_srcp: assert property (p_srcp) else $error("public src kept");
  property p_fgn;
    IN_VALID && IN_READY && IN_FROM_OP && IN_DST_ADDR != PUB_ADDR
      |=> ##1 OUT_VALID && OUT_DROP;
  endproperty
  a_fgn: assert property (p_fgn) else $error("foreign dst kept");
  property p_c2c;
    cust && IN_PROTO != 8'h02 && priv(IN_SRC_ADDR) && priv(IN_DST_ADDR)
      |=> ##1 !OUT_DROP && OUT_DST_ADDR == $past(IN_DST_ADDR, 2);
  endproperty
  a_c2c: assert property (p_c2c) else $error("local pair altered");
  c_route: cover property (PD_VALID ##1 ROUTE_VALID);
  c_drop: cover property (OUT_VALID && OUT_DROP);
  c_local: cover property (OUT_VALID && OUT_LOCAL);
endmodule // napt_props

// ### tb/op_peer.sv
// Operator-side peer: answers a forwarded packet by swapping its ends.
// Assumes it is fed the fields of the latest forwarded result.
module op_peer (
  input  logic [31:0] fwd_src_addr, fwd_dst_addr, // Forwarded ends
  input  logic [15:0] fwd_src_port, fwd_dst_port, // Forwarded ports
  output logic [31:0] rpl_src_addr, rpl_dst_addr, // Reply ends
  output logic [15:0] rpl_src_port, rpl_dst_port  // Reply ports
);
  // Reply goes back to the public pair it saw as source
  assign rpl_src_addr = fwd_dst_addr;
  assign rpl_src_port = fwd_dst_port;
  assign rpl_dst_addr = fwd_src_addr;
  assign rpl_dst_port = fwd_src_port;
endmodule // op_peer

// ### tb/tb_napt_translation_engine.sv
// Self-checking bench for the translation engine.
// Assumes design, checker and peer model are compiled before it.
module tb_napt_translation_engine;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] PUB = 32'h52a10007;
  localparam logic [50:0] DROP = {3'b010, 48'h0};
  localparam logic [50:0] LOCAL = {3'b001, 48'h0};
  localparam logic [31:0] PV [3] = '{32'h0a2a0000, 32'hac1f0000, 32'hc0a80100};
  logic CLK_SYS = 0, ARST_N = 0, IN_VALID = 0, IN_FROM_OP = 0, IN_ICMP_ERR = 0;
  logic IN_FLOW_END = 0, IN_FTP_VALID = 0, PD_VALID = 0, ADV_VALID = 0;
  logic [7:0] IN_PROTO = 8'h06, PD_LEN = 8'h00;
  logic [15:0] IN_SRC_PORT = 0, IN_DST_PORT = 0, IN_INR_PORT = 0;
  logic [15:0] IN_FTP_PORT = 0, PD_LINK_IDENTIFIER = 0;
  logic [31:0] PUB_ADDR = PUB, IN_SRC_ADDR = 0, IN_DST_ADDR = 0, ADV_PREFIX = 0;
  logic [31:0] IN_INR_ADDR = 0, IN_FTP_ADDR = 0, PD_NEXT_HOP = 0;
  wire IN_READY, OUT_VALID, OUT_DROP, OUT_LOCAL, ROUTE_VALID, ADV_PASS;
  wire [31:0] OUT_SRC_ADDR, OUT_DST_ADDR, OUT_INR_ADDR, OUT_FTP_ADDR, r_sa, r_da;
  wire [15:0] OUT_SRC_PORT, OUT_DST_PORT, OUT_INR_PORT, OUT_FTP_PORT, r_sp, r_dp;
  wire [31:0] ROUTE_PREFIX, ROUTE_NEXT_HOP, ADV_OUT_PREFIX;
  wire [7:0] ROUTE_LEN;
  int miscompares = 0, checked = 0, cycles = 0;
  logic [50:0] qp[$];
  logic [71:0] qr[$];
  logic [95:0] qx[$], aux_in, aux_exp;
  logic [32:0] qa[$];
  logic aux_set = 0, adv_q = 0;
  // Short ticks so ageing fits in the run
  napt_translation_engine #(.TICK_CYCLES(64), .IDLE_S(9'd3))
    u_napt_translation_engine (.*);
  op_peer u_op_peer (.fwd_src_addr(OUT_SRC_ADDR), .fwd_src_port(OUT_SRC_PORT),
    .fwd_dst_addr(OUT_DST_ADDR), .fwd_dst_port(OUT_DST_PORT),
    .rpl_src_addr(r_sa), .rpl_src_port(r_sp), .rpl_dst_addr(r_da),
    .rpl_dst_port(r_dp));
  always #20 CLK_SYS = ~CLK_SYS;
  //////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    if (qp.size() + qr.size() + qx.size() + qa.size() != 0) miscompares++;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Drop or local results compare only the flags
  task automatic chk_pkt(logic [50:0] e);
    logic [47:0] g;
    g = e[50] ? {OUT_DST_ADDR, OUT_DST_PORT} : {OUT_SRC_ADDR, OUT_SRC_PORT};
    if (e[49] || e[48]) g = e[47:0];
    checked++;
    if ({OUT_DROP, OUT_LOCAL, g} !== e[49:0]) begin
      miscompares++;
      $display("CHECK FAILED packet exp %h got %h", e[49:0],
               {OUT_DROP, OUT_LOCAL, g});
    end
  endtask
  // Inner header and announced pair, every result
  task automatic chk_aux(logic [95:0] e);
    checked++;
    if ({OUT_INR_ADDR, OUT_INR_PORT, OUT_FTP_ADDR, OUT_FTP_PORT} !== e) begin
      miscompares++;
      $display("CHECK FAILED inner exp %h got %h", e,
               {OUT_INR_ADDR, OUT_INR_PORT, OUT_FTP_ADDR, OUT_FTP_PORT});
    end
  endtask
  task automatic chk_adv(logic [32:0] e);
    checked++;
    if ({ADV_PASS, ADV_OUT_PREFIX} !== e) begin
      miscompares++;
      $display("CHECK FAILED advert exp %h got %h", e,
               {ADV_PASS, ADV_OUT_PREFIX});
    end
  endtask
  task automatic chk_rt(logic [71:0] e);
    checked++;
    if ({ROUTE_PREFIX, ROUTE_LEN, ROUTE_NEXT_HOP} !== e) begin
      miscompares++;
      $display("CHECK FAILED route exp %h got %h", e,
               {ROUTE_PREFIX, ROUTE_LEN, ROUTE_NEXT_HOP});
    end
  endtask
  // Results are mid-pulse at the falling edge
  always @(negedge CLK_SYS) begin
    if (OUT_VALID === 1'b1) chk_pkt(qp.size() ? qp.pop_front() : 'x);
    if (OUT_VALID === 1'b1) chk_aux(qx.size() ? qx.pop_front() : 'x);
    if (ROUTE_VALID === 1'b1) chk_rt(qr.size() ? qr.pop_front() : 'x);
    if (adv_q === 1'b1) chk_adv(qa.size() ? qa.pop_front() : 'x);
  end
  always @(posedge CLK_SYS) begin
    adv_q <= ADV_VALID;
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      wrap_up;
    end
  end
  // Offer one descriptor; inner and FTP fields carry junk unless aux_set
  task automatic pkt(logic op, logic [7:0] pr, logic [31:0] sa,
    logic [15:0] sp, logic [31:0] da, logic [15:0] dp, logic fe,
    logic [50:0] e);
    logic [95:0] r;
    @(negedge CLK_SYS);
    while (IN_READY !== 1'b1) @(negedge CLK_SYS);
    {IN_FROM_OP, IN_PROTO, IN_SRC_ADDR, IN_SRC_PORT} = {op, pr, sa, sp};
    {IN_DST_ADDR, IN_DST_PORT, IN_FLOW_END} = {da, dp, fe};
    r = aux_set ? aux_in : {$urandom, $urandom, $urandom};
    {IN_INR_ADDR, IN_INR_PORT, IN_FTP_ADDR, IN_FTP_PORT} = r;
    qx.push_back(aux_set ? aux_exp : r);
    IN_VALID = 1'b1;
    qp.push_back(e);
    @(negedge CLK_SYS);
    IN_VALID = 1'b0;
  endtask
  task automatic route(logic [15:0] id, logic [7:0] ln, logic [31:0] nh);
    @(negedge CLK_SYS);
    {PD_VALID, PD_LINK_IDENTIFIER, PD_LEN, PD_NEXT_HOP} = {1'b1, id, ln, nh};
    qr.push_back({8'h0a, id, 8'h00, ln - 8'h28, nh});
    @(negedge CLK_SYS);
    PD_VALID = 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] h0, h1, d0;
    logic [15:0] p0, p1;
    d0 = $urandom(52842);
    d0 = {8'h08, 24'($urandom)};
    h0 = {24'hc0a801, 8'($urandom_range(200, 2))};
    h1 = {8'h0a, 24'($urandom)};
    p0 = 16'($urandom_range(60000, 1024));
    p1 = 16'($urandom_range(60000, 1024));
    repeat (4) @(posedge CLK_SYS);
    @(negedge CLK_SYS) ARST_N = 1'b1;
    route(16'h5601, 8'd60, 32'h0a000105);
    repeat (3) route(16'($urandom), 8'd40 + 8'($urandom_range(24)), $urandom);
    // Private prefixes, then our public one, offered for advertising
    for (int i = 0; i < 4; i++) begin
      @(negedge CLK_SYS) {ADV_VALID, ADV_PREFIX} = {1'b1, i < 3 ? PV[i % 3] : PUB};
      qa.push_back({i == 3, ADV_PREFIX});
    end
    @(negedge CLK_SYS) ADV_VALID = 1'b0;
    pkt(0, 8'h11, h0, p0, d0, 16'd53, 0, {3'b0, PUB, 16'hc000});
    pkt(0, 8'h11, h1, p1, d0, 16'd80, 0, {3'b0, PUB, 16'hc001});
    pkt(0, 8'h11, h0, p0, d0 ^ 32'h00ff0000, 16'd443, 0,
        {3'b0, PUB, 16'hc000});
    repeat (3) @(negedge CLK_SYS);
    pkt(1, 8'h11, r_sa, r_sp, r_da, r_dp, 0, {3'b100, h0, p0});
    pkt(1, 8'h11, d0, 16'd53, PUB, 16'hc005, 0, DROP);
    pkt(1, 8'h11, d0, 16'd53, d0, 16'hc000, 0, DROP);
    pkt(0, 8'h11, h0, p0, h1, p1, 0, {3'b0, h0, p0});
    pkt(0, 8'h02, h1, 16'd0, 32'he0000016, 16'd0, 0, LOCAL);
    pkt(0, 8'h11, d0, p0, d0 ^ 32'h1, 16'd53, 0, DROP);
    // Fill the six free slots; the ninth flow finds no room
    for (int i = 2; i < 9; i++)
      pkt(0, 8'h11, h0, p0 + 16'(i), d0, 16'd53, 0,
          i < 8 ? {3'b0, PUB, 16'hc000 + 16'(i)} : DROP);
    // Idle entries age out; lowest slot is reused
    repeat (300) @(negedge CLK_SYS);
    pkt(1, 8'h11, d0, 16'd80, PUB, 16'hc001, 0, DROP);
    pkt(0, 8'h06, h1, p1, d0, 16'd80, 0, {3'b0, PUB, 16'hc000});
    pkt(0, 8'h06, h1, p1, d0, 16'd80, 1, {3'b0, PUB, 16'hc000});
    pkt(1, 8'h06, d0, 16'd80, PUB, 16'hc000, 0, DROP);
    // FTP pair takes slot 0, its control flow slot 1; errors use both
    {aux_set, IN_FTP_VALID} = 2'b11;
    aux_in = {h1, p1, h0, p0 ^ 16'h1};
    aux_exp = {h1, p1, PUB, 16'hc000};
    pkt(0, 8'h06, h0, p0, d0, 16'd21, 0, {3'b0, PUB, 16'hc001});
    {IN_FTP_VALID, IN_ICMP_ERR} = 2'b01;
    aux_in = {h0, p0 ^ 16'h1, 48'h0};
    aux_exp = {PUB, 16'hc000, 48'h0};
    pkt(0, 8'h01, h0, 16'd0, d0, 16'd0, 0, {3'b0, PUB, 16'h0});
    aux_in = {PUB, 16'hc001, 48'h0};
    aux_exp = {h0, p0, 48'h0};
    pkt(1, 8'h01, d0, 16'd0, PUB, 16'd0, 0, {3'b100, h0, 16'h0});
    {aux_set, IN_ICMP_ERR} = 2'b00;
    repeat (4) @(negedge CLK_SYS);
    wrap_up;
  end
endmodule // tb_napt_translation_engine

bind napt_translation_engine napt_props u_napt_props (.*);
